// *** common/fpc_pkg.sv ***
package fpc_pkg;

	// memory map
	localparam logic [31:0] FLASH_BASE     = 32'h0000_0000;
	localparam logic [31:0] SRAM_BASE      = 32'h2000_0000;
	localparam logic [31:0] ALIAS_BASE     = 32'h2200_0000;
	localparam int          FLASH_TOP      = 14;
	localparam int          SRAM_TOP       = 12;
	localparam int          ALIAS_TOP      = 17;
	localparam int          FLASH_AW       = 12;
	localparam int          SRAM_AW        = 10;
	localparam int          PAGE_AW        = 8;
	localparam int          BLOCK_LSB      = 11;
	localparam int          BLOCK_COUNT    = 8;

	// alias address fields: word index and bit inside the word
	localparam int          ALIAS_WORD_LSB = 7;
	localparam int          ALIAS_BIT_LSB  = 2;

	// command word
	localparam logic [15:0] CMD_KEY        = 16'ha442;
	localparam int          CMD_WRITE      = 0;
	localparam int          CMD_ERASE      = 1;
	localparam int          CMD_MASS_ERASE_CMD     = 2;
	localparam int          CMD_COMMIT     = 3;
	localparam int          CMD_BITS       = 4;

	// fault flags
	localparam int          FAULT_PROG     = 0;
	localparam int          FAULT_READ     = 1;

	// values after reset, shipping load and erase
	localparam logic [7:0]  USEC_RESET     = 8'h18;
	localparam logic [7:0]  MASK_RESET     = 8'hff;
	localparam logic [31:0] ERASED_WORD    = 32'hffff_ffff;

	// operation times in microseconds
	localparam logic [15:0] PROG_TIME_US   = 16'h0014;
	localparam logic [15:0] ERASE_TIME_US  = 16'h0014;
	localparam logic [15:0] COMMIT_TIME_US = 16'h0014;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CELLS,
		ST_WAIT
	} fpc_state_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        fetch;
		logic [31:0] addr;
		logic [31:0] wdata;
	} fpc_bus_req_t;

	function automatic logic [2:0] fpc_block(input logic [31:0] a);
		return a[BLOCK_LSB +: 3];
	endfunction

	function automatic logic fpc_in_region(input logic [31:0] a, input logic [31:0] base, input int top);
		return (a >> top) == (base >> top);
	endfunction

endpackage

// *** design/fpc_controller.sv ***
// Contract
// - SRAM is decoded at base 0x20000000.
// - alias = 0x22000000 + byte offset*32 + bit*4 selects one SRAM bit.
// - alias access touches one bit; writes are atomic in hardware.
// - flash is organised in 1 KB pages, each separately erasable.
// - page erase sets every bit of the page to one.
// - protection per 2 KB pair of pages, with read and program bits.
// - erase/program timing derives from the cycles-per-microsecond reload.
// - reload value set at reset; software updates it after clock changes.
// - program bit one allows program/erase; zero refuses any change.
// - read bit zero allows only instruction fetch, no data access.
// - four combinations: execute-only, write-only, read-only, open.
// - fetch still allowed from execute-only blocks; data reads refused.
// - program/erase on protected block aborts; fault interrupt if masked in.
// - refused read returns zeros and may raise the interrupt.
// - shipped state has every policy bit set to one.
// - uncommitted cleared bits return to one on power-on reset.
// - committed policy values persist across every later reset.
// - erase is either one 1 KB page or the whole array.
// - operations use only target address, write word and command.
// - command starts only with key 0xa442 in the upper half.
// - commit saves program mask if address bit 0 is one, else read mask.
// - policy writes only clear bits; setting a bit is ignored.
`timescale 1ns/100ps
module fpc_controller import fpc_pkg::*; (
	input  wire logic         CLK_SYS_I,         // 10 MHz system clock
	input  wire logic         RST_N_I,           // power-on reset, synchronous
	input  wire logic         FACTORY_LOAD_I,    // restore shipped policy store
	input  wire fpc_bus_req_t BUS_REQ_I,         // processor/debugger access
	output logic      [31:0]  RD_DATA_O,         // read answer
	output logic              RD_VALID_O,        // read answer valid
	input  wire logic         USEC_WR_I,         // load microsecond reload
	input  wire logic [7:0]   USEC_DATA_I,       // reload value
	input  wire logic         PE_MASK_WR_I,      // write program-enable mask
	input  wire logic         RE_MASK_WR_I,      // write read-enable mask
	input  wire logic [7:0]   MASK_DATA_I,       // mask write data
	input  wire logic         ADDR_WR_I,         // load target address
	input  wire logic [31:0]  ADDR_DATA_I,       // target address
	input  wire logic         WORD_WR_I,         // load write word
	input  wire logic [31:0]  WORD_DATA_I,       // write word
	input  wire logic         CMD_WR_I,          // write command register
	input  wire logic [31:0]  CMD_DATA_I,        // key and operation bits
	input  wire logic         IRQ_MASK_WR_I,     // load interrupt mask
	input  wire logic [1:0]   IRQ_MASK_DATA_I,   // fault interrupt mask
	input  wire logic [1:0]   FAULT_CLR_I,       // clear fault flags
	output logic      [7:0]   USEC_RELOAD_O,     // current reload value
	output logic      [7:0]   PROGRAM_ENABLE_O,  // working program mask
	output logic      [7:0]   READ_ENABLE_O,     // working read mask
	output logic      [CMD_BITS-1:0] CMD_STATUS_O, // running operation
	output logic      [1:0]   FAULT_STATUS_O,    // sticky fault flags
	output logic              IRQ_O              // controller interrupt
);

	fpc_state_t          state;
	logic [7:0]          usec_reload_value;
	logic [7:0]          program_enable_mask;
	logic [7:0]          read_enable_mask;
	logic [7:0]          nv_program_mask;
	logic [7:0]          nv_read_mask;
	logic [31:0]         flash_target_address;
	logic [31:0]         flash_write_word;
	logic [CMD_BITS-1:0] flash_command_reg;
	logic [1:0]          flash_irq_mask_reg;
	logic [1:0]          fault;
	logic [1:0]          next_fault;
	logic                irq;
	logic [31:0]         rd_data;
	logic                rd_valid;
	logic [FLASH_AW-1:0] seq_addr;
	logic [FLASH_AW-1:0] end_addr;
	logic [31:0]         seq_data;
	logic                commit_sel;
	logic [15:0]         us_left;
	logic [7:0]          tick_cnt;
	logic                cmd_take;
	logic                cmd_refused;
	logic [CMD_BITS-1:0] next_op;
	logic                op_done;
	logic [31:0]         flash_rdata;
	logic [31:0]         next_rd_data;
	logic                read_refused;
	logic                hit_flash;
	logic                hit_sram;
	logic                hit_alias;
	logic [31:0]         sram_mem [0:(1<<SRAM_AW)-1];

	assign USEC_RELOAD_O    = usec_reload_value;
	assign PROGRAM_ENABLE_O = program_enable_mask;
	assign READ_ENABLE_O    = read_enable_mask;
	assign CMD_STATUS_O     = flash_command_reg;
	assign FAULT_STATUS_O   = fault;
	assign IRQ_O            = irq;
	assign RD_DATA_O        = rd_data;
	assign RD_VALID_O       = rd_valid;

	fpc_flash_array u_array (
		.clk_i     (CLK_SYS_I),
		.wr_en_i   (state == ST_CELLS),
		.wr_addr_i (seq_addr),
		.wr_data_i (seq_data),
		.rd_addr_i (BUS_REQ_I.addr[FLASH_TOP-1:2]),
		.rd_data_o (flash_rdata)
	);

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			usec_reload_value <= USEC_RESET;
		end else if (USEC_WR_I) begin
			usec_reload_value <= USEC_DATA_I;
		end
	end

	// policy store survives every reset; only the shipping load and a commit write it
	always_ff @(posedge CLK_SYS_I) begin
		if (FACTORY_LOAD_I) begin
			nv_program_mask <= MASK_RESET;
			nv_read_mask    <= MASK_RESET;
		end else if (op_done && flash_command_reg[CMD_COMMIT]) begin
			if (commit_sel) begin
				nv_program_mask <= program_enable_mask;
			end else begin
				nv_read_mask <= read_enable_mask;
			end
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			program_enable_mask <= nv_program_mask;
			read_enable_mask    <= nv_read_mask;
		end else begin
			if (PE_MASK_WR_I) begin
				program_enable_mask <= program_enable_mask & MASK_DATA_I;
			end
			if (RE_MASK_WR_I) begin
				read_enable_mask <= read_enable_mask & MASK_DATA_I;
			end
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			flash_target_address <= '0;
			flash_write_word     <= '0;
			flash_irq_mask_reg   <= '0;
		end else begin
			if (ADDR_WR_I) begin
				flash_target_address <= ADDR_DATA_I;
			end
			if (WORD_WR_I) begin
				flash_write_word <= WORD_DATA_I;
			end
			if (IRQ_MASK_WR_I) begin
				flash_irq_mask_reg <= IRQ_MASK_DATA_I;
			end
		end
	end

	// command decode: lowest operation bit wins
	always_comb begin
		next_op = '0;
		if (CMD_DATA_I[CMD_WRITE]) begin
			next_op[CMD_WRITE] = 1'b1;
		end else if (CMD_DATA_I[CMD_ERASE]) begin
			next_op[CMD_ERASE] = 1'b1;
		end else if (CMD_DATA_I[CMD_MASS_ERASE_CMD]) begin
			next_op[CMD_MASS_ERASE_CMD] = 1'b1;
		end else if (CMD_DATA_I[CMD_COMMIT]) begin
			next_op[CMD_COMMIT] = 1'b1;
		end
		cmd_take = CMD_WR_I && (CMD_DATA_I[31:16] == CMD_KEY) && (state == ST_IDLE) && (|next_op);
		cmd_refused = cmd_take && ((((next_op[CMD_WRITE] | next_op[CMD_ERASE])
			&& !program_enable_mask[fpc_block(flash_target_address)])
			|| (next_op[CMD_MASS_ERASE_CMD] && !(&program_enable_mask))));
	end

	assign op_done = (state == ST_WAIT) && (tick_cnt == 8'h00) && (us_left <= 16'h0001);

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			state             <= ST_IDLE;
			flash_command_reg <= '0;
			seq_addr          <= '0;
			end_addr          <= '0;
			seq_data          <= '0;
			commit_sel        <= 1'b0;
			us_left           <= '0;
			tick_cnt          <= '0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (cmd_take && !cmd_refused) begin
						flash_command_reg <= next_op;
						commit_sel        <= flash_target_address[0];
						tick_cnt          <= usec_reload_value;
						if (next_op[CMD_WRITE]) begin
							seq_data <= flash_write_word;
							seq_addr <= flash_target_address[FLASH_TOP-1:2];
							end_addr <= flash_target_address[FLASH_TOP-1:2];
							us_left  <= PROG_TIME_US;
							state    <= ST_CELLS;
						end else if (next_op[CMD_ERASE]) begin
							seq_data <= ERASED_WORD;
							seq_addr <= {flash_target_address[FLASH_TOP-1:10], {PAGE_AW{1'b0}}};
							end_addr <= {flash_target_address[FLASH_TOP-1:10], {PAGE_AW{1'b1}}};
							us_left  <= ERASE_TIME_US;
							state    <= ST_CELLS;
						end else if (next_op[CMD_MASS_ERASE_CMD]) begin
							seq_data <= ERASED_WORD;
							seq_addr <= '0;
							end_addr <= '1;
							us_left  <= ERASE_TIME_US;
							state    <= ST_CELLS;
						end else begin
							us_left <= COMMIT_TIME_US;
							state   <= ST_WAIT;
						end
					end
				end
				ST_CELLS: begin
					tick_cnt <= usec_reload_value;
					if (seq_addr == end_addr) begin
						state <= ST_WAIT;
					end else begin
						seq_addr <= seq_addr + 1'b1;
					end
				end
				ST_WAIT: begin
					if (tick_cnt == 8'h00) begin
						tick_cnt <= usec_reload_value;
						if (op_done) begin
							flash_command_reg <= '0;
							state             <= ST_IDLE;
						end else begin
							us_left <= us_left - 1'b1;
						end
					end else begin
						tick_cnt <= tick_cnt - 1'b1;
					end
				end
			endcase
		end
	end

	// data-side decode
	always_comb begin
		hit_flash    = fpc_in_region(BUS_REQ_I.addr, FLASH_BASE, FLASH_TOP);
		hit_sram     = fpc_in_region(BUS_REQ_I.addr, SRAM_BASE, SRAM_TOP);
		hit_alias    = fpc_in_region(BUS_REQ_I.addr, ALIAS_BASE, ALIAS_TOP);
		read_refused = 1'b0;
		next_rd_data = '0;
		if (hit_flash) begin
			if (BUS_REQ_I.fetch || read_enable_mask[fpc_block(BUS_REQ_I.addr)]) begin
				next_rd_data = flash_rdata;
			end else begin
				read_refused = BUS_REQ_I.valid && !BUS_REQ_I.write;
			end
		end else if (hit_sram) begin
			next_rd_data = sram_mem[BUS_REQ_I.addr[SRAM_TOP-1:2]];
		end else if (hit_alias) begin
			next_rd_data = {31'h0000_0000,
				sram_mem[BUS_REQ_I.addr[ALIAS_TOP-1:ALIAS_WORD_LSB]][BUS_REQ_I.addr[ALIAS_WORD_LSB-1:ALIAS_BIT_LSB]]};
		end
	end

	// bus writes to flash are ignored; alias writes change one bit in one cycle
	always_ff @(posedge CLK_SYS_I) begin
		if (BUS_REQ_I.valid && BUS_REQ_I.write) begin
			if (hit_sram) begin
				sram_mem[BUS_REQ_I.addr[SRAM_TOP-1:2]] <= BUS_REQ_I.wdata;
			end else if (hit_alias) begin
				sram_mem[BUS_REQ_I.addr[ALIAS_TOP-1:ALIAS_WORD_LSB]][BUS_REQ_I.addr[ALIAS_WORD_LSB-1:ALIAS_BIT_LSB]]
					<= BUS_REQ_I.wdata[0];
			end
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			rd_data  <= '0;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= BUS_REQ_I.valid && !BUS_REQ_I.write;
			rd_data  <= (BUS_REQ_I.valid && !BUS_REQ_I.write) ? next_rd_data : '0;
		end
	end

	// sticky faults: a new event wins over a clear in the same cycle
	always_comb begin
		next_fault[FAULT_PROG] = cmd_refused || (fault[FAULT_PROG] && !FAULT_CLR_I[FAULT_PROG]);
		next_fault[FAULT_READ] = read_refused || (fault[FAULT_READ] && !FAULT_CLR_I[FAULT_READ]);
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			fault <= '0;
			irq   <= 1'b0;
		end else begin
			fault <= next_fault;
			irq   <= |(next_fault & flash_irq_mask_reg);
		end
	end

	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);

	a_alias_single_bit: assert property (
		(BUS_REQ_I.valid && !BUS_REQ_I.write && hit_alias) |=> (RD_DATA_O[31:1] == 31'h0000_0000 && RD_VALID_O))
		else $error("alias read returned more than one bit");
	a_alias_write_bit: assert property (
		(BUS_REQ_I.valid && BUS_REQ_I.write && hit_alias) ##2 (BUS_REQ_I.valid && !BUS_REQ_I.write
			&& BUS_REQ_I.addr == $past(BUS_REQ_I.addr, 2)) |=> (RD_DATA_O[0] == $past(BUS_REQ_I.wdata[0], 3)))
		else $error("alias write did not reach the selected bit");
	a_refused_read_zero: assert property (
		(read_refused) |=> (RD_DATA_O == 32'h0000_0000 && FAULT_STATUS_O[FAULT_READ]))
		else $error("protected data read leaked data or set no fault");
	a_fetch_allowed: assert property (
		(BUS_REQ_I.valid && !BUS_REQ_I.write && BUS_REQ_I.fetch && hit_flash) |=> (RD_DATA_O == $past(flash_rdata)))
		else $error("instruction fetch from flash was altered");
	a_protect_abort: assert property (
		(cmd_refused) |=> (state == ST_IDLE && CMD_STATUS_O == '0 && FAULT_STATUS_O[FAULT_PROG]
			&& (IRQ_O == flash_irq_mask_reg[FAULT_PROG] || IRQ_O)))
		else $error("protected program or erase was not aborted");
	a_mask_one_way: assert property (
		($past(RST_N_I)) |-> ((program_enable_mask & ~$past(program_enable_mask)) == 8'h00
			&& (read_enable_mask & ~$past(read_enable_mask)) == 8'h00))
		else $error("policy bit went from zero to one");
	a_erase_ones: assert property (
		(state == ST_CELLS && !flash_command_reg[CMD_WRITE]) |-> (seq_data == ERASED_WORD))
		else $error("erase wrote a word other than all ones");
	a_tick_paced: assert property (
		(state == ST_WAIT && $past(state) == ST_WAIT && us_left != $past(us_left)) |-> ($past(tick_cnt) == 8'h00))
		else $error("microsecond count advanced without a tick");
	a_busy_flag: assert property (
		(state != ST_IDLE) |-> ($onehot(CMD_STATUS_O)))
		else $error("operation bit not held while running");
	a_key_needed: assert property (
		(state == ST_IDLE && CMD_WR_I && CMD_DATA_I[31:16] != CMD_KEY) |=> (state == ST_IDLE && CMD_STATUS_O == '0))
		else $error("command started without the key");
	a_commit_save: assert property (
		(op_done && flash_command_reg[CMD_COMMIT] && commit_sel && !FACTORY_LOAD_I)
			|=> (nv_program_mask == $past(program_enable_mask)))
		else $error("commit did not save the program mask");

	c_program: cover property (cmd_take && next_op[CMD_WRITE] && !cmd_refused ##[1:300] op_done);
	c_page_erase: cover property (state == ST_CELLS && flash_command_reg[CMD_ERASE] && seq_addr == end_addr);
	c_mass_erase: cover property (cmd_take && next_op[CMD_MASS_ERASE_CMD] && !cmd_refused);
	c_refused_read: cover property (read_refused ##1 IRQ_O);

endmodule

// *** design/fpc_flash_array.sv ***
`timescale 1ns/100ps
module fpc_flash_array import fpc_pkg::*; (
	input  wire logic                clk_i,     // system clock
	input  wire logic                wr_en_i,   // write one word
	input  wire logic [FLASH_AW-1:0] wr_addr_i, // word address of write
	input  wire logic [31:0]         wr_data_i, // word to store
	input  wire logic [FLASH_AW-1:0] rd_addr_i, // word address of read
	output logic      [31:0]         rd_data_o  // word read, no latency
);

	// cell array, nonvolatile: no reset
	logic [31:0] cells [0:(1<<FLASH_AW)-1];

	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			cells[wr_addr_i] <= wr_data_i;
		end
	end

	assign rd_data_o = cells[rd_addr_i];

endmodule

// *** verification/fpc_bus_model.sv ***
`timescale 1ns/100ps
module fpc_bus_model import fpc_pkg::*; (
	input  wire logic        clk_i,      // system clock
	output fpc_bus_req_t     req_o,      // access toward controller
	input  wire logic [31:0] rd_data_i,  // read answer
	input  wire logic        rd_valid_i  // read answer strobe
);
	initial req_o = '0;
	// one access held for one edge; released lines flip so stale values never look valid
	task automatic access(input logic wr, input logic fe, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		req_o <= '{1'b1, wr, fe, a, d};
		@(posedge clk_i);
		req_o <= '{1'b0, 1'b0, 1'b0, ~a, ~d};
		#1;
		q = (!wr && rd_valid_i === 1'b1) ? rd_data_i : 'x;
	endtask
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/100ps
module tb_top import fpc_pkg::*; ;
	logic                clk = 1'b0;
	logic                rst_n = 1'b0;
	logic                factory = 1'b1;
	logic                usec_wr, pe_wr, re_wr, addr_wr, word_wr, cmd_wr, irq_wr;
	logic [31:0]         cfg_data, cmd_data, rd_data, q;
	logic [1:0]          fault_clr, fault;
	fpc_bus_req_t        req;
	logic                rd_valid, irq;
	logic [7:0]          usec_o, pe_o, re_o;
	logic [CMD_BITS-1:0] status;
	int                  n_mismatch = 0;
	int                  n_tests = 0;
	int                  usec_cur = 0;

	always #50 clk = ~clk;

	fpc_controller fpc_controller_i (.CLK_SYS_I(clk), .RST_N_I(rst_n), .FACTORY_LOAD_I(factory),
		.BUS_REQ_I(req), .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid), .USEC_WR_I(usec_wr),
		.USEC_DATA_I(cfg_data[7:0]), .PE_MASK_WR_I(pe_wr), .RE_MASK_WR_I(re_wr), .MASK_DATA_I(cfg_data[7:0]),
		.ADDR_WR_I(addr_wr), .ADDR_DATA_I(cfg_data), .WORD_WR_I(word_wr), .WORD_DATA_I(cfg_data),
		.CMD_WR_I(cmd_wr), .CMD_DATA_I(cmd_data), .IRQ_MASK_WR_I(irq_wr), .IRQ_MASK_DATA_I(cfg_data[1:0]),
		.FAULT_CLR_I(fault_clr), .USEC_RELOAD_O(usec_o), .PROGRAM_ENABLE_O(pe_o), .READ_ENABLE_O(re_o),
		.CMD_STATUS_O(status), .FAULT_STATUS_O(fault), .IRQ_O(irq));

	fpc_bus_model fpc_bus_model_i (.clk_i(clk), .req_o(req), .rd_data_i(rd_data), .rd_valid_i(rd_valid));

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic do_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		factory <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		usec_cur = 32'h18;
	endtask

	// sel: 0 reload, 1 program mask, 2 read mask, 3 address, 4 word, 5 irq mask, else fault clear
	task automatic cfg(input int sel, input logic [31:0] d);
		@(posedge clk);
		cfg_data <= d;
		case (sel)
			0: usec_wr <= 1'b1;
			1: pe_wr <= 1'b1;
			2: re_wr <= 1'b1;
			3: addr_wr <= 1'b1;
			4: word_wr <= 1'b1;
			5: irq_wr <= 1'b1;
			default: fault_clr <= d[1:0];
		endcase
		@(posedge clk);
		{usec_wr, pe_wr, re_wr, addr_wr, word_wr, irq_wr, fault_clr} <= '0;
		#1;
		if (sel == 0) usec_cur = d[7:0];
	endtask

	// issue a command and count the cycles its operation bit stays up
	task automatic cmd(input logic [31:0] d, input int exp_n, input logic refused);
		int n;
		@(posedge clk);
		cmd_wr <= 1'b1;
		cmd_data <= d;
		@(posedge clk);
		cmd_wr <= 1'b0;
		#1;
		n = 0;
		if (exp_n != 0) chk("op bit", 32'(d[3:0]), 32'(status));
		if (refused) chk("prog fault and irq", 32'h3, 32'({fault[0], irq}));
		while (status !== '0 && n < 6000) begin
			n++;
			@(posedge clk);
			#1;
		end
		chk("busy cycles", 32'(exp_n), 32'(n));
	endtask

	task automatic prog(input logic [31:0] a, input logic [31:0] d, input logic refused);
		cfg(4, d);
		cfg(3, a);
		cmd(32'ha442_0001, refused ? 0 : 1 + int'(PROG_TIME_US) * (usec_cur + 1), refused);
	endtask

	task automatic rd(input logic fe, input logic [31:0] a, input logic [31:0] exp, input string what);
		fpc_bus_model_i.access(1'b0, fe, a, 32'h0, q);
		chk(what, exp, q);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		fpc_bus_model_i.access(1'b1, 1'b0, a, d, q);
	endtask

	task automatic t_reset();
		chk("reload", 32'h18, 32'(usec_o));
		chk("program mask", 32'hff, 32'(pe_o));
		chk("read mask", 32'hff, 32'(re_o));
		chk("idle", 32'h0, 32'({status, fault, irq}));
		cmd(32'ha442_0004, 4096 + int'(ERASE_TIME_US) * (usec_cur + 1), 1'b0);
		rd(1'b0, 32'h0000_3ffc, ERASED_WORD, "mass erased");
		$display("test reset finished");
	endtask

	task automatic t_program();
		cfg(0, 32'h09);
		prog(32'h0000_0100, 32'h1234_5678, 1'b0);
		rd(1'b0, 32'h0000_0100, 32'h1234_5678, "word");
		rd(1'b0, 32'h0000_0104, ERASED_WORD, "next word");
		cfg(0, 32'h00);
		cmd(32'ha443_0001, 0, 1'b0);
		prog(32'h0000_03fc, 32'h1111_1111, 1'b0);
		prog(32'h0000_0400, 32'h2222_2222, 1'b0);
		cfg(3, 32'h0000_0200);
		cmd(32'ha442_0002, 256 + int'(ERASE_TIME_US) * (usec_cur + 1), 1'b0);
		rd(1'b0, 32'h0000_03fc, ERASED_WORD, "page erased");
		rd(1'b0, 32'h0000_0100, ERASED_WORD, "page erased");
		rd(1'b0, 32'h0000_0400, 32'h2222_2222, "next page kept");
		$display("test program finished");
	endtask

	task automatic t_protect();
		cfg(5, 32'h1);
		cfg(1, 32'hfd);
		cfg(1, 32'hff);
		chk("program mask", 32'hfd, 32'(pe_o));
		prog(32'h0000_0800, 32'h3333_3333, 1'b1);
		cfg(6, 32'h3);
		cfg(3, 32'h0000_0c00);
		cmd(32'ha442_0002, 0, 1'b1);
		cfg(6, 32'h3);
		cmd(32'ha442_0004, 0, 1'b1);
		rd(1'b0, 32'h0000_0800, ERASED_WORD, "read-only block");
		prog(32'h0000_07fc, 32'h4444_4444, 1'b0);
		rd(1'b0, 32'h0000_07fc, 32'h4444_4444, "open block");
		cfg(6, 32'h3);
		@(posedge clk);
		#1;
		chk("fault cleared", 32'h0, 32'({fault, irq}));
		$display("test protect finished");
	endtask

	task automatic t_read();
		cfg(5, 32'h2);
		prog(32'h0000_1000, 32'h5555_5555, 1'b0);
		cfg(2, 32'hf9);
		rd(1'b0, 32'h0000_1000, 32'h0, "read-protected");
		chk("read fault and irq", 32'h3, 32'({fault[1], irq}));
		rd(1'b1, 32'h0000_1000, 32'h5555_5555, "fetch");
		prog(32'h0000_1004, 32'h6666_6666, 1'b0);
		rd(1'b1, 32'h0000_1004, 32'h6666_6666, "fetch");
		rd(1'b0, 32'h0000_0800, 32'h0, "execute-only");
		rd(1'b1, 32'h0000_0800, ERASED_WORD, "execute-only fetch");
		rd(1'b0, 32'h0000_1800, ERASED_WORD, "next block");
		$display("test read finished");
	endtask

	task automatic t_commit();
		cfg(3, 32'h1);
		cmd(32'ha442_0008, int'(COMMIT_TIME_US) * (usec_cur + 1), 1'b0);
		do_reset();
		chk("program mask kept", 32'hfd, 32'(pe_o));
		chk("read mask restored", 32'hff, 32'(re_o));
		cfg(2, 32'hef);
		cfg(3, 32'h0);
		cmd(32'ha442_0008, int'(COMMIT_TIME_US) * (usec_cur + 1), 1'b0);
		do_reset();
		chk("read mask kept", 32'hef, 32'(re_o));
		chk("program mask kept", 32'hfd, 32'(pe_o));
		$display("test commit finished");
	endtask

	task automatic t_sram();
		wr(32'h2000_0010, 32'hffff_ffff);
		wr(32'h2200_020c, 32'h0);
		rd(1'b0, 32'h2000_0010, 32'hffff_fff7, "alias clear");
		rd(1'b0, 32'h2200_0220, 32'h1, "alias read");
		wr(32'h2200_0220, 32'h0);
		rd(1'b0, 32'h2200_0220, 32'h0, "alias write read");
		rd(1'b0, 32'h2000_0010, 32'hffff_fef7, "alias bit eight");
		rd(1'b0, 32'h2200_020c, 32'h0, "alias read");
		$display("test sram finished");
	endtask

	initial begin
		{usec_wr, pe_wr, re_wr, addr_wr, word_wr, cmd_wr, irq_wr, fault_clr} = '0;
		cfg_data = '0;
		cmd_data = '0;
		do_reset();
		t_reset();
		t_program();
		t_protect();
		t_read();
		t_sram();
		t_commit();
		conclude();
	end

	initial begin
		#3_000_000;
		n_mismatch++;
		conclude();
	end
endmodule
